/* common/i2c_irq_pkg.sv */
package i2c_irq_pkg;

    // Word addresses in the CPU I/O space
    localparam logic [15:0] OFS_OWN_ADDRESS = 16'h1a00;
    localparam logic [15:0] OFS_INT_MASK = 16'h1a04;
    localparam logic [15:0] OFS_INT_STATUS = 16'h1a08;
    localparam logic [15:0] OFS_SCL_LOW_DIVIDER = 16'h1a0c;
    localparam logic [15:0] OFS_SCL_HIGH_DIVIDER = 16'h1a10;
    localparam logic [15:0] OFS_BYTE_COUNT = 16'h1a14;
    localparam logic [15:0] OFS_RX_BUFFER = 16'h1a18;
    localparam logic [15:0] OFS_TARGET_ADDRESS = 16'h1a1c;
    localparam logic [15:0] OFS_TX_BUFFER = 16'h1a20;
    localparam logic [15:0] OFS_MODE_CONTROL = 16'h1a24;
    localparam logic [15:0] OFS_INT_VECTOR = 16'h1a28;
    localparam logic [15:0] OFS_EXTENDED_MODE = 16'h1a2c;
    localparam logic [15:0] OFS_CLOCK_PRESCALER = 16'h1a30;
    localparam logic [15:0] OFS_PERIPH_IDENT_ONE = 16'h1a34;
    localparam logic [15:0] OFS_PERIPH_IDENT_TWO = 16'h1a38;

    // Event index, also mask bit position and priority (0 highest)
    localparam int NUM_EVENTS = 7;
    localparam int IDX_ARB_LOST = 0;
    localparam int IDX_NACK = 1;
    localparam int IDX_REGS_READY = 2;
    localparam int IDX_RX_READY = 3;
    localparam int IDX_TX_READY = 4;
    localparam int IDX_STOP_DETECT = 5;
    localparam int IDX_ADDRESSED = 6;

    // Status register places the addressed-as-target flag at bit 9
    localparam int STATUS_ADDRESSED_BIT = 9;
    localparam int STATUS_W1C_TOP = 5;

    // Mode control free-run bit and own address width
    localparam int MODE_FREE_BIT = 14;
    localparam int OWN_ADDR_W = 10;

    // Reset values: only the transmit-ready flag starts set
    localparam logic [6:0] FLAGS_RESET = 7'h10;
    localparam logic [6:0] MASK_RESET = 7'h00;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Vector value when nothing is pending; codes are index plus one
    localparam logic [15:0] VEC_NONE = 16'h0000;
    localparam logic [7:0] GENERAL_CALL = 8'h00;

    // Bus events from the protocol engine, one-cycle pulses
    typedef struct packed {
        logic arb_lost;
        logic illegal_cond;
        logic nack;
        logic is_master;
        logic regs_ready;
        logic rx_copy;
        logic tx_copy;
        logic stop;
        logic addr_valid;
        logic [7:0] addr_byte;
        logic [15:0] rx_data;
    } bus_events_t;

    // Register port request from CPU or DMA
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } io_req_t;

endpackage

/* rtl/i2c_event_and_irq_logic.sv */
// Behaviour
// - Vector register shows binary code of the pending event.
// - Reading vector clears that flag; remaining flags raise a new request.
// - With several pending, a vector read clears only the highest priority.
// - Each event owns a status flag and mask bit; event sets flag.
// - Flag reaches CPU only when mask bit is 1.
// - Arbitration loss or illegal start/stop sets arbitration-lost flag.
// - As master, missing acknowledge sets no-acknowledge flag.
// - Completed programmed command sets registers-ready flag.
// - Receive copy into buffer sets receive-ready flag, pollable.
// - Transmit copy into shift register sets transmit-ready flag, ack or not.
// - Detected stop condition sets stop-detected flag.
// - Own address or all-zero general call sets addressed flag.
// - Interrupt drives its own dedicated CPU line.
// - Receive copy pulses receive DMA sync event.
// - Transmit copy pulses transmit DMA sync event, ack or not.
// - Debug suspend halts when free-run is 0, runs when 1.
// - Registers sit at fixed 16-bit word addresses in I/O space.
// - Writing 1 clears a status flag in bits 5 to 0, 0 leaves it; the addressed flag at bit 9 ignores writes.
// - Vector reads zero when nothing is pending.
// - Mask bits 6 down to 0 in documented event order.
`timescale 1ns/1ps
`default_nettype none

module i2c_event_and_irq_logic #(
    parameter logic [15:0] IDENT_ONE = 16'h0101, // Arbitrary value
    parameter logic [15:0] IDENT_TWO = 16'h0202 // Arbitrary value
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire i2c_irq_pkg::io_req_t io_req,
    output logic [15:0] io_rdata,
    output logic io_rvalid,
    // Bus events from the protocol engine
    input wire i2c_irq_pkg::bus_events_t events,
    // Debug suspend request
    input wire logic dbg_suspend,
    // CPU interrupt and DMA sync
    output logic irq,
    output logic rx_dma_sync,
    output logic tx_dma_sync,
    // Engine controls
    output logic halt,
    output logic [15:0] tx_data
);

    // Flag layout and vector codes assume seven events
    localparam int N = i2c_irq_pkg::NUM_EVENTS;

    if (N != 7) begin : g_bad_count
        $error("event count must be seven");
    end

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Index of highest-priority set bit, N when none
    function automatic logic [2:0] top_index(input logic [6:0] f);
        logic [2:0] idx;
        idx = 3'h7;
        for (int i = N - 1; i >= 0; i--) begin
            if (f[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Vector code: index plus one, zero when idle
    function automatic logic [15:0] vec_code(input logic [6:0] f);
        logic [2:0] idx;
        idx = top_index(f);
        if (idx == 3'h7) begin
            return i2c_irq_pkg::VEC_NONE;
        end
        return {13'h0000, 3'(idx + 3'h1)};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [6:0] flags_ff;
    logic [6:0] nxt_flags;
    logic [6:0] mask_ff;
    logic [6:0] nxt_mask;
    logic [6:0] set_vec;
    logic [6:0] clr_vec;
    logic [i2c_irq_pkg::OWN_ADDR_W-1:0] own_addr_ff;
    logic [15:0] scl_low_ff;
    logic [15:0] scl_high_ff;
    logic [15:0] count_ff;
    logic [15:0] target_ff;
    logic [15:0] tx_buf_ff;
    logic [15:0] rx_buf_ff;
    logic [15:0] mode_ff;
    logic [15:0] ext_mode_ff;
    logic [15:0] presc_ff;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    logic irq_ff;
    logic rx_sync_ff;
    logic tx_sync_ff;
    logic halt_ff;
    logic addr_hit;
    logic vec_rd;
    logic sts_wr;

    ////////////////////////////////////////////////////////////////////////
    // Event decode

    // Own-address or general-call match on the incoming address byte
    assign addr_hit = events.addr_valid &&
        ((events.addr_byte[7:1] == own_addr_ff[6:0]) ||
         (events.addr_byte == i2c_irq_pkg::GENERAL_CALL));

    // Flag set terms, one per event
    always_comb begin
        set_vec = 7'h00;
        set_vec[i2c_irq_pkg::IDX_ARB_LOST] = events.arb_lost | events.illegal_cond;
        set_vec[i2c_irq_pkg::IDX_NACK] = events.nack & events.is_master;
        set_vec[i2c_irq_pkg::IDX_REGS_READY] = events.regs_ready;
        set_vec[i2c_irq_pkg::IDX_RX_READY] = events.rx_copy;
        set_vec[i2c_irq_pkg::IDX_TX_READY] = events.tx_copy;
        set_vec[i2c_irq_pkg::IDX_STOP_DETECT] = events.stop;
        set_vec[i2c_irq_pkg::IDX_ADDRESSED] = addr_hit;
    end

    assign vec_rd = io_req.rd && (io_req.addr == i2c_irq_pkg::OFS_INT_VECTOR);
    assign sts_wr = io_req.wr && (io_req.addr == i2c_irq_pkg::OFS_INT_STATUS);

    // Clear terms: write-one-to-clear and vector read
    always_comb begin
        logic [2:0] idx;
        idx = top_index(flags_ff);
        clr_vec = 7'h00;
        if (sts_wr) begin
            clr_vec[i2c_irq_pkg::STATUS_W1C_TOP:0] =
                io_req.wdata[i2c_irq_pkg::STATUS_W1C_TOP:0];
        end
        if (vec_rd && idx != 3'h7) begin
            clr_vec[idx] = 1'b1;
        end
    end

    // Set wins over clear so no event is lost
    assign nxt_flags = (flags_ff & ~clr_vec) | set_vec;

    always_comb begin
        nxt_mask = mask_ff;
        if (io_req.wr && io_req.addr == i2c_irq_pkg::OFS_INT_MASK) begin
            nxt_mask = io_req.wdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags and mask

    // Sticky event flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= i2c_irq_pkg::FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Mask register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= i2c_irq_pkg::MASK_RESET;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // Dedicated interrupt line, level while any enabled flag is set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_flags & nxt_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA sync and suspend

    // One-cycle sync pulses, issued whatever the acknowledge turns out to be
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_ff <= 1'b0;
            tx_sync_ff <= 1'b0;
        end else begin
            rx_sync_ff <= events.rx_copy;
            tx_sync_ff <= events.tx_copy;
        end
    end

    // Halt request to the engine; it finishes the bus transaction itself
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            halt_ff <= 1'b0;
        end else begin
            halt_ff <= dbg_suspend & ~mode_ff[i2c_irq_pkg::MODE_FREE_BIT];
        end
    end

    // Receive buffer captures the shift register at each copy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_ff <= i2c_irq_pkg::REG_RESET;
        end else if (events.rx_copy) begin
            rx_buf_ff <= events.rx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    // Plain read-write registers; unlisted addresses ignore writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            own_addr_ff <= '0;
            scl_low_ff <= i2c_irq_pkg::REG_RESET;
            scl_high_ff <= i2c_irq_pkg::REG_RESET;
            count_ff <= i2c_irq_pkg::REG_RESET;
            target_ff <= i2c_irq_pkg::REG_RESET;
            tx_buf_ff <= i2c_irq_pkg::REG_RESET;
            mode_ff <= i2c_irq_pkg::REG_RESET;
            ext_mode_ff <= i2c_irq_pkg::REG_RESET;
            presc_ff <= i2c_irq_pkg::REG_RESET;
        end else if (io_req.wr) begin
            if (io_req.addr == i2c_irq_pkg::OFS_OWN_ADDRESS) begin
                own_addr_ff <= io_req.wdata[i2c_irq_pkg::OWN_ADDR_W-1:0];
            end else if (io_req.addr == i2c_irq_pkg::OFS_SCL_LOW_DIVIDER) begin
                scl_low_ff <= io_req.wdata;
            end else if (io_req.addr == i2c_irq_pkg::OFS_SCL_HIGH_DIVIDER) begin
                scl_high_ff <= io_req.wdata;
            end else if (io_req.addr == i2c_irq_pkg::OFS_BYTE_COUNT) begin
                count_ff <= io_req.wdata;
            end else if (io_req.addr == i2c_irq_pkg::OFS_TARGET_ADDRESS) begin
                target_ff <= io_req.wdata;
            end else if (io_req.addr == i2c_irq_pkg::OFS_TX_BUFFER) begin
                tx_buf_ff <= io_req.wdata;
            end else if (io_req.addr == i2c_irq_pkg::OFS_MODE_CONTROL) begin
                mode_ff <= io_req.wdata;
            end else if (io_req.addr == i2c_irq_pkg::OFS_EXTENDED_MODE) begin
                ext_mode_ff <= io_req.wdata;
            end else if (io_req.addr == i2c_irq_pkg::OFS_CLOCK_PRESCALER) begin
                presc_ff <= io_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= i2c_irq_pkg::REG_RESET;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= io_req.rd;
            if (!io_req.rd) begin
                rdata_ff <= rdata_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_OWN_ADDRESS) begin
                rdata_ff <= {6'h00, own_addr_ff};
            end else if (io_req.addr == i2c_irq_pkg::OFS_INT_MASK) begin
                rdata_ff <= {9'h000, mask_ff};
            end else if (io_req.addr == i2c_irq_pkg::OFS_INT_STATUS) begin
                rdata_ff <= {6'h00, flags_ff[i2c_irq_pkg::IDX_ADDRESSED], 3'h0,
                             flags_ff[i2c_irq_pkg::STATUS_W1C_TOP:0]};
            end else if (io_req.addr == i2c_irq_pkg::OFS_SCL_LOW_DIVIDER) begin
                rdata_ff <= scl_low_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_SCL_HIGH_DIVIDER) begin
                rdata_ff <= scl_high_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_BYTE_COUNT) begin
                rdata_ff <= count_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_RX_BUFFER) begin
                rdata_ff <= rx_buf_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_TARGET_ADDRESS) begin
                rdata_ff <= target_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_TX_BUFFER) begin
                rdata_ff <= tx_buf_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_MODE_CONTROL) begin
                rdata_ff <= mode_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_INT_VECTOR) begin
                rdata_ff <= vec_code(flags_ff);
            end else if (io_req.addr == i2c_irq_pkg::OFS_EXTENDED_MODE) begin
                rdata_ff <= ext_mode_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_CLOCK_PRESCALER) begin
                rdata_ff <= presc_ff;
            end else if (io_req.addr == i2c_irq_pkg::OFS_PERIPH_IDENT_ONE) begin
                rdata_ff <= IDENT_ONE;
            end else if (io_req.addr == i2c_irq_pkg::OFS_PERIPH_IDENT_TWO) begin
                rdata_ff <= IDENT_TWO;
            end else begin
                rdata_ff <= i2c_irq_pkg::REG_RESET;
            end
        end
    end

    // Outputs straight from flops
    assign io_rdata = rdata_ff;
    assign io_rvalid = rvalid_ff;
    assign irq = irq_ff;
    assign rx_dma_sync = rx_sync_ff;
    assign tx_dma_sync = tx_sync_ff;
    assign halt = halt_ff;
    assign tx_data = tx_buf_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    vec_code_a: assert property (vec_rd |=> io_rdata == vec_code($past(flags_ff)))
        else $error("vector code mismatch");
    vec_zero_a: assert property (vec_rd && flags_ff == 7'h00 |=> io_rdata == 16'h0000)
        else $error("vector not zero when idle");
    vec_clear_a: assert property (vec_rd && flags_ff != 7'h00 && set_vec == 7'h00 && !sts_wr
        |=> $countones($past(flags_ff)) - $countones(flags_ff) == 1 &&
            !flags_ff[top_index($past(flags_ff))])
        else $error("vector read cleared wrong flags");
    irq_gate_a: assert property (irq == |(flags_ff & mask_ff))
        else $error("interrupt does not follow enabled flags");
    w1c_clear_a: assert property (sts_wr && io_req.wdata[0] && !set_vec[0] |=> !flags_ff[0])
        else $error("write one did not clear");
    set_wins_a: assert property (set_vec[3] |=> flags_ff[3])
        else $error("receive flag not set");
    arb_set_a: assert property (events.illegal_cond |=> flags_ff[0])
        else $error("illegal condition not flagged");
    nack_set_a: assert property (events.nack && events.is_master |=> flags_ff[1])
        else $error("no-acknowledge not flagged");
    regs_ready_a: assert property (events.regs_ready |=> flags_ff[2])
        else $error("registers-ready not flagged");
    stop_set_a: assert property (events.stop |=> flags_ff[5])
        else $error("stop not flagged");
    gen_call_a: assert property (events.addr_valid && events.addr_byte == 8'h00 |=> flags_ff[6])
        else $error("general call not flagged");
    rx_sync_a: assert property (events.rx_copy |=> rx_dma_sync ##1 !rx_dma_sync || $past(events.rx_copy))
        else $error("receive sync pulse wrong");
    tx_sync_a: assert property (events.tx_copy |=> tx_dma_sync && flags_ff[4])
        else $error("transmit sync or flag missing");
    halt_ctl_a: assert property (##1 halt == ($past(dbg_suspend) && !$past(mode_ff[14])))
        else $error("halt does not follow suspend and free-run");

    cov_multi_c: cover property (vec_rd && $countones(flags_ff & mask_ff) > 1 ##1 irq);
    cov_irq_c: cover property (!irq ##1 irq);
    cov_halt_c: cover property (dbg_suspend ##1 halt);

endmodule

`default_nettype wire

/* verification/host_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Far side: the second DMA controller consuming the sync pulses
module host_sink_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Sync lines from the peripheral
    input wire logic rx_dma_sync,
    input wire logic tx_dma_sync,
    // Observed activity
    output logic [7:0] rx_cnt_ff,
    output logic [7:0] tx_cnt_ff
);

    ////////////////////////////////////////////////////////////////
    // One transfer per pulse; a stretched pulse would show as extra counts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_ff <= 8'h00;
            tx_cnt_ff <= 8'h00;
        end else begin
            rx_cnt_ff <= rx_cnt_ff + {7'h00, rx_dma_sync};
            tx_cnt_ff <= tx_cnt_ff + {7'h00, tx_dma_sync};
        end
    end

endmodule

`default_nettype wire

/* verification/tb_i2c_event_and_irq_logic.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_event_and_irq_logic;

    localparam logic [15:0] ID1 = 16'h3c01; // Arbitrary identification value
    localparam logic [15:0] ID2 = 16'h3c02; // Arbitrary identification value

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    i2c_irq_pkg::io_req_t io_req = '0;
    i2c_irq_pkg::bus_events_t events = '0;
    i2c_irq_pkg::bus_events_t all_ev;
    logic dbg_suspend = 1'b0;
    logic [15:0] io_rdata, tx_data;
    logic io_rvalid, irq, rx_dma_sync, tx_dma_sync, halt;
    logic [7:0] rx_cnt, tx_cnt;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int bit_pos;
    // Flag index per stimulus kind; -1 means the event must be refused
    int exp_idx[9] = '{0, 0, 1, -1, 2, 3, 4, 5, 6};
    logic [15:0] rw_addr[9] = '{i2c_irq_pkg::OFS_OWN_ADDRESS, i2c_irq_pkg::OFS_SCL_LOW_DIVIDER,
        i2c_irq_pkg::OFS_SCL_HIGH_DIVIDER, i2c_irq_pkg::OFS_BYTE_COUNT, i2c_irq_pkg::OFS_TARGET_ADDRESS,
        i2c_irq_pkg::OFS_TX_BUFFER, i2c_irq_pkg::OFS_MODE_CONTROL, i2c_irq_pkg::OFS_EXTENDED_MODE,
        i2c_irq_pkg::OFS_CLOCK_PRESCALER};

    // Stands for the prescaled clock; its divider setting is software's duty
    always #25 mclk = ~mclk;

    i2c_event_and_irq_logic #(.IDENT_ONE(ID1), .IDENT_TWO(ID2)) u_i2c_event_and_irq_logic (
        .mclk(mclk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .events(events), .dbg_suspend(dbg_suspend), .irq(irq), .rx_dma_sync(rx_dma_sync),
        .tx_dma_sync(tx_dma_sync), .halt(halt), .tx_data(tx_data));

    host_sink_model u_host_sink_model (
        .mclk(mclk), .rst_n(rst_n), .rx_dma_sync(rx_dma_sync), .tx_dma_sync(tx_dma_sync),
        .rx_cnt_ff(rx_cnt), .tx_cnt_ff(tx_cnt));

    ////////////////////////////////////////////////////////////////
    // Compare tasks
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Register port: strobe for one cycle, answer one edge later
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk);
        io_req.wr = 1'b1;
        io_req.addr = a;
        io_req.wdata = d;
        @(negedge mclk);
        io_req.wr = 1'b0;
    endtask

    task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp, input string what);
        @(negedge mclk);
        io_req.rd = 1'b1;
        io_req.addr = a;
        @(negedge mclk);
        io_req.rd = 1'b0;
        chk1("io_rvalid", 1'b1, io_rvalid);
        chk16(what, exp, io_rdata);
    endtask

    // Event pulses last one cycle; sync outputs are looked at the cycle after
    task automatic pulse(input i2c_irq_pkg::bus_events_t v);
        @(negedge mclk);
        events = v;
        @(negedge mclk);
        events = '0;
        chk1("rx_dma_sync", v.rx_copy, rx_dma_sync);
        chk1("tx_dma_sync", v.tx_copy, tx_dma_sync);
    endtask

    function automatic i2c_irq_pkg::bus_events_t ev_of(input int k, input logic [7:0] ab);
        i2c_irq_pkg::bus_events_t v;
        v = '0;
        v.rx_data = 16'h5a00;
        v.addr_byte = ab;
        case (k)
            0: v.arb_lost = 1'b1;
            1: v.illegal_cond = 1'b1;
            2: begin
                v.nack = 1'b1;
                v.is_master = 1'b1;
            end
            3: v.nack = 1'b1;
            4: v.regs_ready = 1'b1;
            5: v.rx_copy = 1'b1;
            6: v.tx_copy = 1'b1;
            7: v.stop = 1'b1;
            default: v.addr_valid = 1'b1;
        endcase
        return v;
    endfunction

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A hang costs a mismatch; the tests need well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        chk1("irq", 1'b0, irq);
        chk_rd(i2c_irq_pkg::OFS_INT_STATUS, 16'h0010, "int_status");
        chk_rd(i2c_irq_pkg::OFS_INT_MASK, 16'h0000, "int_mask");
        chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'h0005, "int_vector");
        chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'h0000, "int_vector");
        // Storage registers, then read-only and unlisted places
        for (int i = 0; i < 9; i++) begin
            reg_wr(rw_addr[i], 16'ha5c3);
            chk_rd(rw_addr[i], (i == 0) ? 16'h01c3 : 16'ha5c3, "storage");
        end
        chk16("tx_data", 16'ha5c3, tx_data);
        reg_wr(i2c_irq_pkg::OFS_INT_MASK, 16'hffff);
        chk_rd(i2c_irq_pkg::OFS_INT_MASK, 16'h007f, "int_mask");
        reg_wr(i2c_irq_pkg::OFS_INT_MASK, 16'h0000);
        reg_wr(i2c_irq_pkg::OFS_PERIPH_IDENT_ONE, 16'hffff);
        reg_wr(i2c_irq_pkg::OFS_INT_VECTOR, 16'hffff);
        chk_rd(i2c_irq_pkg::OFS_PERIPH_IDENT_ONE, ID1, "ident_one");
        chk_rd(i2c_irq_pkg::OFS_PERIPH_IDENT_TWO, ID2, "ident_two");
        chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'h0000, "int_vector");
        chk_rd(16'h1a3c, 16'h0000, "unlisted");
        // Debug suspend with free-run off, then on
        dbg_suspend = 1'b1;
        repeat (2) @(negedge mclk);
        chk1("halt", 1'b1, halt);
        reg_wr(i2c_irq_pkg::OFS_MODE_CONTROL, 16'h4000);
        @(negedge mclk);
        chk1("halt", 1'b0, halt);
        dbg_suspend = 1'b0;
        // Each event alone: flag position, mask position, vector code
        reg_wr(i2c_irq_pkg::OFS_OWN_ADDRESS, 16'h0055);
        for (int k = 0; k < 9; k++) begin
            pulse(ev_of(k, 8'haa));
            if (exp_idx[k] < 0) begin
                chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'h0000, "refused nack");
            end else begin
                bit_pos = (exp_idx[k] == 6) ? 9 : exp_idx[k];
                chk_rd(i2c_irq_pkg::OFS_INT_STATUS, 16'h0001 << bit_pos, "int_status");
                reg_wr(i2c_irq_pkg::OFS_INT_MASK, 16'h007f & ~(16'h0001 << exp_idx[k]));
                @(negedge mclk);
                chk1("irq", 1'b0, irq);
                reg_wr(i2c_irq_pkg::OFS_INT_MASK, 16'h0001 << exp_idx[k]);
                @(negedge mclk);
                chk1("irq", 1'b1, irq);
                chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'(exp_idx[k] + 1), "int_vector");
                @(negedge mclk);
                chk1("irq", 1'b0, irq);
                chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'h0000, "int_vector");
            end
        end
        chk_rd(i2c_irq_pkg::OFS_RX_BUFFER, 16'h5a00, "rx_buffer");
        // General call matches, a foreign address does not
        pulse(ev_of(8, 8'h00));
        chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'h0007, "general call");
        pulse(ev_of(8, 8'h02));
        chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'h0000, "foreign address");
        // All events at once: write-one-to-clear, masking, priority order
        all_ev = '0;
        for (int k = 0; k < 9; k++) begin
            all_ev = all_ev | ev_of(k, 8'haa);
        end
        reg_wr(i2c_irq_pkg::OFS_INT_MASK, 16'h0000);
        pulse(all_ev);
        reg_wr(i2c_irq_pkg::OFS_INT_STATUS, 16'h0000);
        chk_rd(i2c_irq_pkg::OFS_INT_STATUS, 16'h023f, "int_status");
        chk1("irq", 1'b0, irq);
        reg_wr(i2c_irq_pkg::OFS_INT_STATUS, 16'h0001);
        chk_rd(i2c_irq_pkg::OFS_INT_STATUS, 16'h023e, "int_status");
        reg_wr(i2c_irq_pkg::OFS_INT_MASK, 16'h0040);
        for (int c = 2; c < 8; c++) begin
            chk_rd(i2c_irq_pkg::OFS_INT_VECTOR, 16'(c), "int_vector");
            @(negedge mclk);
            chk1("irq", c < 7, irq);
            if (c == 2) begin
                chk_rd(i2c_irq_pkg::OFS_INT_STATUS, 16'h023c, "int_status");
            end
        end
        // Stop event and its write-one-to-clear in one cycle: the set wins
        @(negedge mclk);
        events = ev_of(7, 8'haa);
        io_req.wr = 1'b1;
        io_req.addr = i2c_irq_pkg::OFS_INT_STATUS;
        io_req.wdata = 16'h0020;
        @(negedge mclk);
        events = '0;
        io_req.wr = 1'b0;
        chk_rd(i2c_irq_pkg::OFS_INT_STATUS, 16'h0020, "int_status");
        chk16("rx sync count", 16'h0002, {8'h00, rx_cnt});
        chk16("tx sync count", 16'h0002, {8'h00, tx_cnt});
        wrap_up();
    end

endmodule

`default_nettype wire
